// ==== verilog/uart_status_flags.sv ====
// What this block does
// - status byte bit order txe..tmp
// - reset and standby load 0x84
// - writing one never sets error flags
// - zero clears only after reading one
// - tx data write clears tx_buffer_empty
// - tx_on off or shifter load sets it
// - clean reception sets rx_buffer_full
// - rx data read clears rx_buffer_full
// - errors or rx_on off keep rx state
// - completion while full sets overrun
// - overrun discards the new data byte; rx_mp still takes its bit
// - overrun stops reception, sync transmit too
// - stop bit zero sets framing fault
// - framing error stores data, not full
// - framing fault halts reception, sync both
// - parity mismatch sets parity fault
// - parity error stores data, halts reception
// - rx_on off keeps error flags
// - tx_complete sets on tx_on off/end while tx_buffer_empty
// - tx_complete clears with tx_buffer_empty
// - tx_complete, rx_mp read only; tx_mp r/w
// - tx_on low holds tx_buffer_empty high
// - rx_multiproc_bit captures received bit
// - tx_multiproc_bit drives transmitted bit
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "uart_status_params.svh"
module uart_status_flags (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire uart_status_pkg::wb_adr_t adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // line side events from the shifters
  input  wire logic                    tx_load_i,
  input  wire logic                    tx_last_i,
  input  wire logic                    rx_done_i,
  input  wire logic                    rx_stop_i,
  input  wire logic                    rx_par_i,
  input  wire logic                    rx_mpb_i,
  input  wire logic [7:0]              rx_data_i,
  // to the shifters
  output logic [7:0]                   tx_data_o,
  output logic                         tx_mpb_o,
  output logic                         tx_run_o,
  output logic                         rx_run_o
);
  import uart_status_pkg::*;

  status_evt_if ev ();
  logic [13:0] sync_q;

  // every line pin is resampled together, so the character fields stay
  // aligned with the rx_done pulse that qualifies them
  line_sync #(.W(14)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({tx_load_i, tx_last_i, rx_done_i, rx_stop_i, rx_par_i, rx_mpb_i, rx_data_i}),
    .q_o   (sync_q)
  );
  assign ev.tx_load  = sync_q[13];
  assign ev.tx_last  = sync_q[12];
  assign ev.rx_done  = sync_q[11];
  assign ev.rx_stop  = sync_q[10];
  assign ev.rx_par   = sync_q[9];
  assign ev.rx_mpb   = sync_q[8];
  assign ev.rx_data  = sync_q[7:0];

  function automatic logic hit(input wb_adr_t a, input wb_adr_t r);
    hit = (a == r);
  endfunction

  // register state
  byte_t       sts_q, sts_d;
  byte_t       rd_seen_q, rd_seen_d;   // flags read as one since last clear
  byte_t       ctl_q, ctl_d;
  byte_t       txd_q, txd_d;
  byte_t       rxd_q, rxd_d;
  logic [31:0] dat_q, dat_d;
  logic        ack_q, ack_d;
  logic        stby_q, stby_d;

  logic req, wr, rd, wlane;
  logic tx_on, rx_on, sync_md, mp_md, podd, stby;
  logic rx_halt, rx_ok, par_bad, frm_bad;

  always_comb begin
    req   = cyc_i & stb_i & ~ack_q;
    wr    = req & we_i;
    rd    = req & ~we_i;
    wlane = sel_i[0];
    tx_on   = ctl_q[`CTL_TXON_BIT];
    rx_on   = ctl_q[`CTL_RXON_BIT];
    podd    = ctl_q[`CTL_PODD_BIT];
    sync_md = ctl_q[`CTL_SYNC_BIT];
    mp_md   = ctl_q[`CTL_MP_BIT];
    stby    = ctl_q[`CTL_STBY_BIT];
    // any error flag blocks reception
    rx_halt = sts_q[`STS_OVR_BIT] | sts_q[`STS_FRM_BIT] | sts_q[`STS_PAR_BIT];
    rx_ok   = ev.rx_done & rx_on & ~rx_halt;
    frm_bad = ~sync_md & ~ev.rx_stop;
    par_bad = ~sync_md & ~mp_md & ((^ev.rx_data) ^ ev.rx_par ^ podd);
  end

  // bus, control and data registers
  always_comb begin
    ack_d  = req;
    dat_d  = dat_q;
    ctl_d  = ctl_q;
    txd_d  = txd_q;
    stby_d = stby;
    if (rd) begin
      dat_d = 32'h0;
      if (hit(adr_i, `ADR_STATUS))  dat_d[7:0] = sts_q;
      if (hit(adr_i, `ADR_CONTROL)) dat_d[7:0] = ctl_q;
      if (hit(adr_i, `ADR_TXDATA))  dat_d[7:0] = txd_q;
      if (hit(adr_i, `ADR_RXDATA))  dat_d[7:0] = rxd_q;
    end
    if (wr && wlane && hit(adr_i, `ADR_CONTROL)) ctl_d = dat_i[7:0];
    if (wr && wlane && hit(adr_i, `ADR_TXDATA) && tx_on) txd_d = dat_i[7:0];
  end

  // status flags
  always_comb begin
    byte_t w;
    logic  txe_clr, txe_set, txwr;
    w = dat_i[7:0];
    sts_d     = sts_q;
    rd_seen_d = rd_seen_q;
    rxd_d     = rxd_q;
    txwr = wr & wlane & hit(adr_i, `ADR_TXDATA) & tx_on;
    // remember which flags software has seen set
    if (rd && hit(adr_i, `ADR_STATUS)) rd_seen_d = rd_seen_q | sts_q;
    if (wr && wlane && hit(adr_i, `ADR_STATUS)) begin
      // ones are ignored except tmp, which takes the written bit; zeros clear only what was seen
      for (int b = 3; b < 8; b++) begin
        if (!w[b] && rd_seen_q[b]) begin
          sts_d[b]     = 1'b0;
          rd_seen_d[b] = 1'b0;
        end
      end
      sts_d[`STS_TMP_BIT] = w[`STS_TMP_BIT];
    end
    txe_clr = (sts_q[`STS_TXE_BIT] & ~sts_d[`STS_TXE_BIT]) | txwr;
    if (txwr) sts_d[`STS_TXE_BIT] = 1'b0;
    if (txe_clr) sts_d[`STS_TXC_BIT] = 1'b0;
    if (rd && hit(adr_i, `ADR_RXDATA)) sts_d[`STS_RXF_BIT] = 1'b0;
    // hardware sets land last so they win
    txe_set = ~tx_on | ev.tx_load;
    if (txe_set) sts_d[`STS_TXE_BIT] = 1'b1;
    if (~tx_on | (ev.tx_last & sts_q[`STS_TXE_BIT])) sts_d[`STS_TXC_BIT] = 1'b1;
    if (rx_ok) begin
      if (mp_md && !sync_md) sts_d[`STS_RMP_BIT] = ev.rx_mpb;
      if (sts_q[`STS_RXF_BIT]) begin
        sts_d[`STS_OVR_BIT] = 1'b1;
      end else if (frm_bad || par_bad) begin
        rxd_d = ev.rx_data;
        if (frm_bad) sts_d[`STS_FRM_BIT] = 1'b1;
        if (par_bad) sts_d[`STS_PAR_BIT] = 1'b1;
      end else begin
        rxd_d = ev.rx_data;
        sts_d[`STS_RXF_BIT] = 1'b1;
      end
    end
    // rx_on low touches nothing here
    if (stby) begin
      sts_d     = `STS_RESET;
      rd_seen_d = 8'h00;
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_q     <= `STS_RESET;
      rd_seen_q <= 8'h00;
      ctl_q     <= 8'h00;
      txd_q     <= 8'h00;
      rxd_q     <= 8'h00;
      dat_q     <= 32'h0;
      ack_q     <= 1'b0;
      stby_q    <= 1'b0;
    end else begin
      sts_q     <= sts_d;
      rd_seen_q <= rd_seen_d;
      ctl_q     <= ctl_d;
      txd_q     <= txd_d;
      rxd_q     <= rxd_d;
      dat_q     <= dat_d;
      ack_q     <= ack_d;
      stby_q    <= stby_d;
    end
  end

  // shifter control outputs, registered
  logic [7:0] txo_q;
  logic       mpo_q, txr_q, rxr_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txo_q <= 8'h00;
      mpo_q <= 1'b0;
      txr_q <= 1'b0;
      rxr_q <= 1'b0;
    end else begin
      txo_q <= txd_q;
      mpo_q <= sts_q[`STS_TMP_BIT];
      // sync mode: overrun or framing fault stops transmit too
      txr_q <= tx_on & ~(sync_md & rx_halt);
      rxr_q <= rx_on & ~rx_halt;
    end
  end

  assign dat_o     = dat_q;
  assign ack_o     = ack_q;
  assign tx_data_o = txo_q;
  assign tx_mpb_o  = mpo_q;
  assign tx_run_o  = txr_q;
  assign rx_run_o  = rxr_q;
endmodule // uart_status_flags

// ==== verilog/uart_status_params.svh ====
`ifndef UART_STATUS_PARAMS_SVH
`define UART_STATUS_PARAMS_SVH
// status bit positions
`define STS_TXE_BIT  3'd7
`define STS_RXF_BIT  3'd6
`define STS_OVR_BIT  3'd5
`define STS_FRM_BIT  3'd4
`define STS_PAR_BIT  3'd3
`define STS_TXC_BIT  3'd2
`define STS_RMP_BIT  3'd1
`define STS_TMP_BIT  3'd0
// status reset value
`define STS_RESET    8'h84
// word offsets on the register bus
`define ADR_STATUS   4'h0
`define ADR_CONTROL  4'h1
`define ADR_TXDATA   4'h2
`define ADR_RXDATA   4'h3
// control bit positions
`define CTL_TXON_BIT 3'd0
`define CTL_RXON_BIT 3'd1
`define CTL_PODD_BIT 3'd2
`define CTL_SYNC_BIT 3'd3
`define CTL_MP_BIT   3'd4
`define CTL_STBY_BIT 3'd5
`endif

// ==== verilog/uart_status_pkg.sv ====
package uart_status_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] wb_adr_t;
endpackage

// ==== verilog/status_evt_if.sv ====
`timescale 1ns/100ps
// events from the datapath into the flag logic
interface status_evt_if;
  logic tx_load;    // holding reg moved into shifter
  logic tx_last;    // last bit of character sent
  logic rx_done;    // character assembled
  logic rx_stop;    // first stop bit sample
  logic rx_par;     // received parity bit
  logic [7:0] rx_data;
  logic rx_mpb;
  modport src (output tx_load, tx_last, rx_done, rx_stop, rx_par, rx_data, rx_mpb);
  modport dst (input  tx_load, tx_last, rx_done, rx_stop, rx_par, rx_data, rx_mpb);
endinterface

// ==== verilog/line_sync.sv ====
`timescale 1ns/100ps
// two-stage synchroniser for the line event pins
module line_sync #(
  parameter int W = 12
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

  // first stage feeds only the second
  always_comb begin
    s1_d = d_i;
    s2_d = s1_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q_o = s2_q;
endmodule // line_sync

// ==== test/uart_status_flags_chk.sv ====
`timescale 1ns/100ps
// bus and flag relations seen from the top-level pins
module uart_status_flags_chk (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     we_i,
  input wire uart_status_pkg::wb_adr_t adr_i,
  input wire logic [3:0]               sel_i,
  input wire logic [31:0]              dat_i,
  input wire logic [31:0]              dat_o,
  input wire logic                     ack_o,
  input wire logic                     tx_mpb_o,
  input wire logic                     tx_run_o,
  input wire logic                     rx_run_o
);
  import uart_status_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request taken, then its status read or write answered
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_stat_rd; s_take ##0 !we_i && adr_i == 4'h0 ##1 ack_o; endsequence
  sequence s_stat_wr; s_take ##0 we_i && sel_i[0] && adr_i == 4'h0 ##1 ack_o; endsequence
  a_ack_answer: assert property (s_take |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && dat_o == 32'h0 && !tx_run_o && !rx_run_o) else $error("reset out");
  a_tx_complete_needs_txe: assert property (s_stat_rd |-> !dat_o[2] || dat_o[7])
    else $error("tx_complete without empty");
  a_mpb_write: assert property (s_stat_wr |=> tx_mpb_o == $past(dat_i[0]))
    else $error("mpb not written");
  a_err_halts_rx: assert property (s_stat_rd ##0 |dat_o[5:3] |-> !rx_run_o)
    else $error("rx runs on error");
endmodule // uart_status_flags_chk
bind uart_status_flags uart_status_flags_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .tx_mpb_o(tx_mpb_o), .tx_run_o(tx_run_o), .rx_run_o(rx_run_o));

// ==== test/line_partner.sv ====
`timescale 1ns/100ps
// far end of the line: delivers characters and shifter events
module line_partner (
  input  wire logic clk_i,
  output logic      rx_done_o, rx_stop_o, rx_par_o, rx_mpb_o, tx_load_o, tx_last_o,
  output logic [7:0] rx_data_o
);
  initial begin
    {rx_done_o, rx_stop_o, rx_par_o, rx_mpb_o, tx_load_o, tx_last_o} = 6'h0;
    rx_data_o = 8'h00;
  end
  // fields held across the sync delay, then inverted so stale data is never trusted
  task automatic send_char(input logic [7:0] d, input logic stp, par, mpb);
    @(posedge clk_i);
    {rx_data_o, rx_stop_o, rx_par_o, rx_mpb_o} <= {d, stp, par, mpb};
    @(posedge clk_i);
    rx_done_o <= 1'b1;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    {rx_data_o, rx_stop_o, rx_par_o, rx_mpb_o} <= ~{d, stp, par, mpb};
  endtask
  // one-cycle shifter event: load when last is 0, end of character when 1
  task automatic pulse_tx(input logic last);
    @(posedge clk_i);
    {tx_last_o, tx_load_o} <= {last, ~last};
    @(posedge clk_i);
    {tx_last_o, tx_load_o} <= 2'b00;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // line_partner

// ==== test/uart_status_flags_tb_top.sv ====
`timescale 1ns/100ps
module uart_status_flags_tb_top;
  import uart_status_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, tx_mpb_o, tx_run_o, rx_run_o;
  logic        tx_load_i, tx_last_i, rx_done_i, rx_stop_i, rx_par_i, rx_mpb_i;
  wb_adr_t     adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  byte_t       rx_data_i, tx_data_o;
  int          failures, samples_checked, cycles;
  uart_status_flags u_dut (.*);
  line_partner u_line (.clk_i(clk_i), .rx_done_o(rx_done_i), .rx_stop_o(rx_stop_i),
    .rx_par_o(rx_par_i), .rx_mpb_o(rx_mpb_i), .tx_load_o(tx_load_i), .tx_last_o(tx_last_i),
    .rx_data_o(rx_data_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard: far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // classic cycle: held until ack is sampled, data taken at that edge
  task automatic wb(input logic w, input wb_adr_t a, input byte_t d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) failures++;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic st(input byte_t e);
    wb(1'b0, 4'h0, 8'h00);
    chk("status", {24'h0, e}, q);
  endtask
  task automatic t_reset;
    st(8'h84);
    wb(1'b1, 4'h0, 8'hFF);
    st(8'h85);
    chk("mpb out", 32'h1, {31'h0, tx_mpb_o});
    wb(1'b1, 4'h0, 8'h00);
    st(8'h84);
    wb(1'b0, 4'hF, 8'h00);
    chk("unmapped", 32'h0, q);
    $display("t_reset done");
  endtask
  task automatic t_tx;
    wb(1'b1, 4'h1, 8'h01);
    wb(1'b1, 4'h2, 8'h5A);
    st(8'h00);
    chk("tx data", 32'h5A, {24'h0, tx_data_o});
    chk("tx run", 32'h1, {31'h0, tx_run_o});
    u_line.pulse_tx(1'b0);
    st(8'h80);
    u_line.pulse_tx(1'b1);
    st(8'h84);
    wb(1'b1, 4'h0, 8'h00);
    st(8'h00);
    wb(1'b1, 4'h1, 8'h00);
    st(8'h84);
    $display("t_tx done");
  endtask
  task automatic t_rx;
    wb(1'b1, 4'h1, 8'h02);
    u_line.send_char(8'h3C, 1'b1, 1'b0, 1'b0);
    st(8'hC4);
    wb(1'b0, 4'h3, 8'h00);
    st(8'h84);
    u_line.send_char(8'h11, 1'b1, 1'b0, 1'b0);
    u_line.send_char(8'h22, 1'b1, 1'b0, 1'b0);
    st(8'hE4);
    wb(1'b0, 4'h3, 8'h00);
    chk("rx data", 32'h11, q);
    wb(1'b1, 4'h1, 8'h20);
    st(8'h84);
    wb(1'b1, 4'h1, 8'h02);
    $display("t_rx done");
  endtask
  task automatic t_err;
    u_line.send_char(8'h7E, 1'b0, 1'b0, 1'b0);
    wb(1'b1, 4'h0, 8'h00);
    st(8'h94);
    wb(1'b0, 4'h3, 8'h00);
    chk("rx data", 32'h7E, q);
    wb(1'b1, 4'h0, 8'h00);
    u_line.send_char(8'h01, 1'b1, 1'b0, 1'b0);
    st(8'h8C);
    chk("rx run", 32'h0, {31'h0, rx_run_o});
    wb(1'b1, 4'h1, 8'h00);
    st(8'h8C);
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b1, 4'h1, 8'h06);
    u_line.send_char(8'h01, 1'b1, 1'b0, 1'b0);
    st(8'hC4);
    wb(1'b0, 4'h3, 8'h00);
    wb(1'b1, 4'h1, 8'h12);
    u_line.send_char(8'h40, 1'b1, 1'b0, 1'b1);
    st(8'hC6);
    $display("t_err done");
  endtask
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {3'b000, 4'h0, 4'h1, 32'h0};
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    stop_test();
  end
endmodule // uart_status_flags_tb_top
